// [verilog/mdm_pkg.sv]
// constants shared by the multiply/divide/accumulate coprocessor files
// assumes one clock and a synchronous active-high reset everywhere
package mdm_pkg;
  localparam int          MODE_W      = 7;
  localparam int          OPC_W       = 4;
  localparam int          OUTSEL_W    = 3;
  localparam int          OPND_W      = 16;
  localparam int          RES_W       = 32;
  localparam int          FLAG_W      = 4;
  // mode word field positions
  localparam int          OPC_LSB     = 0;
  localparam int          OUTSEL_LSB  = 4;
  // operation codes
  localparam logic [3:0]  OP_CLEAR    = 4'h0;
  localparam logic [3:0]  OP_INIT16   = 4'h1;
  localparam logic [3:0]  OP_INIT32   = 4'h2;
  localparam logic [3:0]  OP_READ     = 4'h3;
  localparam logic [3:0]  OP_MULU     = 4'h4;
  localparam logic [3:0]  OP_MULS     = 4'h5;
  localparam logic [3:0]  OP_MAC      = 4'h7;
  localparam logic [3:0]  OP_DIVU     = 4'h8;
  localparam logic [3:0]  OP_DIVS     = 4'h9;
  // output half select
  localparam logic [2:0]  OUT_LO      = 3'h0;
  localparam logic [2:0]  OUT_HI      = 3'h1;
  // flag patterns, order carry overflow zero negative
  localparam logic [3:0]  FLAGS_NONE  = 4'h0;
  localparam logic [3:0]  FLAGS_OVF   = 4'h4;
  // reset values
  localparam logic [6:0]  MODE_RST    = 7'h00;
  localparam logic [31:0] RES_RST     = 32'h0000_0000;
  // divider timing: one step per bit plus load and sign fix
  localparam int          DIV_STEPS   = 16;
  localparam logic [3:0]  DIV_LAST    = 4'hF;
  localparam int          DIV_LAT     = 19;

  // pick the returned half; only code 1 gives the upper half
  function automatic logic [15:0] sel_half(input logic [31:0] res, input logic [2:0] outsel);
    sel_half = (outsel == OUT_HI) ? res[31:16] : res[15:0];
  endfunction

  function automatic logic is_div(input logic [3:0] opc);
    is_div = (opc == OP_DIVU) || (opc == OP_DIVS);
  endfunction
endpackage

// [verilog/mdm_div.sv]
// serial 16/16 divider, restoring, magnitude core with sign fix-up
// assumes start is a one-cycle pulse issued only while idle
`timescale 1ns/1ps
`default_nettype none
module mdm_div (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        start_i,
  input  wire logic        signed_i,
  input  wire logic [15:0] dividend_i,
  input  wire logic [15:0] divisor_i,
  output logic             done_o,
  output logic [15:0]      quo_o,
  output logic [15:0]      rem_o
);
  typedef enum logic [1:0] {DIV_IDLE, DIV_RUN, DIV_FIX} mdm_div_e;
  mdm_div_e     state_r;
  logic [3:0]   cnt_r;
  logic [15:0]  q_r;
  logic [15:0]  rem_r;
  logic [15:0]  dvs_r;
  logic         qneg_r;
  logic         rneg_r;
  logic [16:0]  acc;
  logic [16:0]  diff;
  logic         a_neg;
  logic         b_neg;

  assign a_neg = signed_i && dividend_i[15];
  assign b_neg = signed_i && divisor_i[15];
  assign acc   = {rem_r, q_r[15]};
  assign diff  = acc - {1'b0, dvs_r};

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      state_r <= DIV_IDLE;
      cnt_r   <= 4'h0;
    end
    else
    begin
      unique case (state_r)
        DIV_IDLE:
        begin
          if (start_i)
          begin
            state_r <= DIV_RUN;
            cnt_r   <= 4'h0;
          end
        end
        DIV_RUN:
        begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == mdm_pkg::DIV_LAST)
            state_r <= DIV_FIX;
        end
        DIV_FIX:
          state_r <= DIV_IDLE;
      endcase
    end
  end

  // zero divisor bounded
  // zero divisor runs the same steps: quotient magnitude all ones before sign fix-up, no hang
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      q_r    <= 16'h0000;
      rem_r  <= 16'h0000;
      dvs_r  <= 16'h0000;
      qneg_r <= 1'b0;
      rneg_r <= 1'b0;
    end
    else if (state_r == DIV_IDLE && start_i)
    begin
      q_r    <= a_neg ? (~dividend_i + 16'h0001) : dividend_i;
      dvs_r  <= b_neg ? (~divisor_i + 16'h0001) : divisor_i;
      rem_r  <= 16'h0000;
      qneg_r <= a_neg ^ b_neg;
      rneg_r <= a_neg;
    end
    else if (state_r == DIV_RUN)
    begin
      q_r   <= {q_r[14:0], ~diff[16]};
      rem_r <= diff[16] ? acc[15:0] : diff[15:0];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      done_o <= 1'b0;
      quo_o  <= 16'h0000;
      rem_o  <= 16'h0000;
    end
    else
    begin
      done_o <= (state_r == DIV_FIX);
      if (state_r == DIV_FIX)
      begin
        quo_o <= qneg_r ? (~q_r + 16'h0001) : q_r;
        rem_o <= rneg_r ? (~rem_r + 16'h0001) : rem_r;
      end
    end
  end

  property p_div_done_18;
    @(posedge core_clk_i) disable iff (srst_i)
      (state_r == DIV_IDLE && start_i) |-> ##18 done_o;
  endproperty
  a_div_done_18: assert property (p_div_done_18) else $error("divider done late");

  property p_div_done_pulse;
    @(posedge core_clk_i) disable iff (srst_i)
      done_o |=> !done_o;
  endproperty
  a_div_done_pulse: assert property (p_div_done_pulse) else $error("divider done longer than one");
endmodule
`default_nettype wire

// [verilog/mdm_coproc.sv]
// multiply / divide / accumulate coprocessor beside the cpu core
// assumes the cpu holds off new transfers while busy is high
`timescale 1ns/1ps
`default_nettype none
module mdm_coproc (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        mode_word_write_op_i,
  input  wire logic [6:0]  mode_word_i,
  input  wire logic        operand_transfer_op_i,
  input  wire logic        initial_value_load_op_i,
  input  wire logic [15:0] dst_opnd_i,
  input  wire logic [15:0] src_opnd_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [15:0]      half_result_o,
  output logic [3:0]       carry_overflow_zero_negative_o
);
  typedef enum logic {MDM_IDLE, MDM_DIV_WAIT} mdm_state_e;
  mdm_state_e   state_r;
  logic [6:0]   mode_r;
  logic [31:0]  res_r;
  logic [31:0]  res_nxt;
  logic         ovf_r;
  logic         ovf_nxt;
  logic [3:0]   opc;
  logic [2:0]   outsel;
  logic         idle;
  logic         take_mode;
  logic         take_xfer;
  logic         take_init;
  logic         div_start;
  logic         div_done;
  logic [15:0]  div_quo;
  logic [15:0]  div_rem;
  logic [31:0]  prod_u;
  logic [31:0]  prod_s;
  logic [31:0]  mac_sum;
  logic         mac_ovf;

  assign opc    = mode_r[mdm_pkg::OPC_LSB +: mdm_pkg::OPC_W];
  assign outsel = mode_r[mdm_pkg::OUTSEL_LSB +: mdm_pkg::OUTSEL_W];
  assign idle   = (state_r == MDM_IDLE);
  assign take_mode = mode_word_write_op_i && idle;
  assign take_xfer = operand_transfer_op_i && idle;
  assign take_init = initial_value_load_op_i && idle;
  assign div_start = take_xfer && mdm_pkg::is_div(opc);
  assign busy_o    = !idle;

  assign prod_u  = {16'h0000, dst_opnd_i} * {16'h0000, src_opnd_i};
  assign prod_s  = 32'($signed(dst_opnd_i) * $signed(src_opnd_i));
  assign mac_sum = prod_s + res_r;
  // overflow on same-sign inputs, flipped sum
  assign mac_ovf = (prod_s[31] == res_r[31]) && (mac_sum[31] != prod_s[31]);

  mdm_div u_div (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .start_i    (div_start),
    .signed_i   (opc == mdm_pkg::OP_DIVS),
    .dividend_i (dst_opnd_i),
    .divisor_i  (src_opnd_i),
    .done_o     (div_done),
    .quo_o      (div_quo),
    .rem_o      (div_rem)
  );

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      mode_r <= mdm_pkg::MODE_RST;
    else if (take_mode)
      mode_r <= mode_word_i;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      state_r <= MDM_IDLE;
    else
    begin
      unique case (state_r)
        MDM_IDLE:
          if (div_start)
            state_r <= MDM_DIV_WAIT;
        MDM_DIV_WAIT:
          if (div_done)
            state_r <= MDM_IDLE;
      endcase
    end
  end

  // reserved codes fall to the default arm: result left as is
  always_comb
  begin
    res_nxt = res_r;
    if (take_mode && mode_word_i[3:0] == mdm_pkg::OP_CLEAR)
      res_nxt = mdm_pkg::RES_RST;
    else if (take_init)
    begin
      unique case (opc)
        mdm_pkg::OP_INIT16: res_nxt = {16'h0000, src_opnd_i};
        mdm_pkg::OP_INIT32: res_nxt = {dst_opnd_i, src_opnd_i};
        default:            res_nxt = res_r;
      endcase
    end
    else if (take_xfer)
    begin
      unique case (opc)
        mdm_pkg::OP_MULU: res_nxt = prod_u;
        mdm_pkg::OP_MULS: res_nxt = prod_s;
        mdm_pkg::OP_MAC:  res_nxt = mac_sum;
        default:          res_nxt = res_r;
      endcase
    end
    else if (div_done && !idle)
      res_nxt = {div_rem, div_quo};
  end

  always_comb
  begin
    ovf_nxt = ovf_r;
    if (take_xfer && opc == mdm_pkg::OP_MAC)
      ovf_nxt = mac_ovf;
    else if ((take_xfer || take_init) && opc != mdm_pkg::OP_READ)
      ovf_nxt = 1'b0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      res_r <= mdm_pkg::RES_RST;
      ovf_r <= 1'b0;
    end
    else
    begin
      res_r <= res_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  // answer registered so the cpu sees final data with done
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      done_o                         <= 1'b0;
      half_result_o                  <= 16'h0000;
      carry_overflow_zero_negative_o <= mdm_pkg::FLAGS_NONE;
    end
    else
    begin
      done_o <= (take_xfer && !div_start) || (div_done && !idle);
      if ((take_xfer && !div_start) || (div_done && !idle))
      begin
        half_result_o <= mdm_pkg::sel_half(res_nxt, outsel);
        if (take_xfer && opc == mdm_pkg::OP_MAC && mac_ovf)
          carry_overflow_zero_negative_o <= mdm_pkg::FLAGS_OVF;
        else
          carry_overflow_zero_negative_o <= mdm_pkg::FLAGS_NONE;
      end
    end
  end

  sequence s_div_wait;
    busy_o ##17 busy_o;
  endsequence
  sequence s_div_answer;
    done_o && !busy_o && half_result_o == mdm_pkg::sel_half(res_r, outsel);
  endsequence
  property p_div_latency;
    @(posedge core_clk_i) disable iff (srst_i)
      div_start |-> ##1 s_div_wait ##1 s_div_answer;
  endproperty
  a_div_latency: assert property (p_div_latency) else $error("division answer not at 19");

  property p_mul_one_cycle;
    @(posedge core_clk_i) disable iff (srst_i)
      (take_xfer && !take_mode && (opc == mdm_pkg::OP_MULU || opc == mdm_pkg::OP_MULS))
      |=> done_o && carry_overflow_zero_negative_o == mdm_pkg::FLAGS_NONE
          && res_r == (($past(opc) == mdm_pkg::OP_MULU) ? $past(prod_u) : $past(prod_s));
  endproperty
  a_mul_one_cycle: assert property (p_mul_one_cycle) else $error("multiply result wrong");

  property p_clear;
    @(posedge core_clk_i) disable iff (srst_i)
      (take_mode && mode_word_i[3:0] == mdm_pkg::OP_CLEAR) |=> res_r == 32'h0000_0000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear code left result");

  property p_init16;
    @(posedge core_clk_i) disable iff (srst_i)
      (take_init && opc == mdm_pkg::OP_INIT16) |=> res_r == {16'h0000, $past(src_opnd_i)};
  endproperty
  a_init16: assert property (p_init16) else $error("16-bit preload wrong");

  property p_init32;
    @(posedge core_clk_i) disable iff (srst_i)
      (take_init && opc == mdm_pkg::OP_INIT32)
      |=> res_r == {$past(dst_opnd_i), $past(src_opnd_i)} && !ovf_r;
  endproperty
  a_init32: assert property (p_init32) else $error("32-bit preload wrong");

  property p_read;
    @(posedge core_clk_i) disable iff (srst_i)
      (take_xfer && opc == mdm_pkg::OP_READ && !take_mode)
      |=> $stable(res_r) && $stable(ovf_r) && done_o
          && carry_overflow_zero_negative_o == mdm_pkg::FLAGS_NONE;
  endproperty
  a_read: assert property (p_read) else $error("read code disturbed state");

  property p_mac_ovf;
    @(posedge core_clk_i) disable iff (srst_i)
      (take_xfer && opc == mdm_pkg::OP_MAC && mac_ovf)
      |=> ovf_r && carry_overflow_zero_negative_o == mdm_pkg::FLAGS_OVF;
  endproperty
  a_mac_ovf: assert property (p_mac_ovf) else $error("overflow not flagged");

  property p_ovf_sticky;
    @(posedge core_clk_i) disable iff (srst_i)
      (ovf_r && !take_xfer && !take_init) |=> ovf_r;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow dropped by itself");

  property p_hold;
    @(posedge core_clk_i) disable iff (srst_i)
      (idle && !take_mode && !take_xfer && !take_init) |=> $stable(res_r);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed while quiet");
endmodule
`default_nettype wire

// [sim/mdm_host.sv]
// host cpu model issuing the three coprocessor transfer kinds
// assumes the bench never calls a task while a division is running
`timescale 1ns/1ps
`default_nettype none
module mdm_host (
  input  wire logic  core_clk_i,
  input  wire logic  done_i,
  output logic       mode_word_write_op_o,
  output logic [6:0] mode_word_o,
  output logic       operand_transfer_op_o,
  output logic       initial_value_load_op_o,
  output logic [15:0] dst_opnd_o,
  output logic [15:0] src_opnd_o
);
  initial
  begin
    mode_word_write_op_o    = 1'b0;
    mode_word_o             = 7'h00;
    operand_transfer_op_o   = 1'b0;
    initial_value_load_op_o = 1'b0;
    dst_opnd_o              = 16'h0000;
    src_opnd_o              = 16'h0000;
  end

  task automatic write_mode(input logic [6:0] m);
    @(negedge core_clk_i);
    mode_word_write_op_o = 1'b1;
    mode_word_o = m;
    @(negedge core_clk_i);
    mode_word_write_op_o = 1'b0;
    // released lines flip so stale values never pass
    mode_word_o = ~m;
  endtask

  task automatic load(input logic [15:0] d, input logic [15:0] s);
    @(negedge core_clk_i);
    initial_value_load_op_o = 1'b1;
    dst_opnd_o = d;
    src_opnd_o = s;
    @(negedge core_clk_i);
    initial_value_load_op_o = 1'b0;
    dst_opnd_o = ~d;
    src_opnd_o = ~s;
  endtask

  // latency counted from the taking edge; 41 means no answer
  task automatic xfer(input logic [15:0] d, input logic [15:0] s, output int lat);
    @(negedge core_clk_i);
    operand_transfer_op_o = 1'b1;
    dst_opnd_o = d;
    src_opnd_o = s;
    @(negedge core_clk_i);
    operand_transfer_op_o = 1'b0;
    dst_opnd_o = ~d;
    src_opnd_o = ~s;
    // single-cycle answers already stand at this falling edge
    lat = 1;
    while (done_i !== 1'b1 && lat <= 40)
    begin
      @(negedge core_clk_i);
      lat++;
    end
  endtask
endmodule
`default_nettype wire

// [sim/mdm_coproc_tb.sv]
// self-checking bench for the coprocessor, result model in the bench
// assumes the host model drives all transfers on falling edges
`timescale 1ns/1ps
`default_nettype none
module mdm_coproc_tb;
  logic        core_clk_i = 1'b0;
  logic        srst_i     = 1'b1;
  logic        mw, xf, ld, busy_o, done_o;
  logic [6:0]  mw_word;
  logic [15:0] dst, src, half_result_o;
  logic [3:0]  flags;
  logic [31:0] res;
  logic [6:0]  mode;
  logic [19:0] exp_q[$];
  int          bad_count = 0;
  int          cmp_count = 0;
  int          seed = 32'h7c4e;
  logic [6:0]  tbl[11] = '{7'h04, 7'h14, 7'h05, 7'h15, 7'h08, 7'h18, 7'h09, 7'h19,
                            7'h06, 7'h13, 7'h03};

  always #12.5 core_clk_i = ~core_clk_i;

  mdm_coproc i_mdm_coproc (
    .core_clk_i                     (core_clk_i),
    .srst_i                         (srst_i),
    .mode_word_write_op_i           (mw),
    .mode_word_i                    (mw_word),
    .operand_transfer_op_i          (xf),
    .initial_value_load_op_i        (ld),
    .dst_opnd_i                     (dst),
    .src_opnd_i                     (src),
    .busy_o                         (busy_o),
    .done_o                         (done_o),
    .half_result_o                  (half_result_o),
    .carry_overflow_zero_negative_o (flags)
  );

  mdm_host i_mdm_host (
    .core_clk_i              (core_clk_i),
    .done_i                  (done_o),
    .mode_word_write_op_o    (mw),
    .mode_word_o             (mw_word),
    .operand_transfer_op_o   (xf),
    .initial_value_load_op_o (ld),
    .dst_opnd_o              (dst),
    .src_opnd_o              (src)
  );

  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // result watcher: one note per answer
  always @(negedge core_clk_i)
  begin
    if (done_o === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(32'hDEAD, 32'h0);
      else
        check({12'h000, half_result_o, flags}, {12'h000, exp_q.pop_front()});
    end
  end

  task automatic wm(input logic [6:0] m);
    mode = m;
    if (m[3:0] == mdm_pkg::OP_CLEAR)
      res = mdm_pkg::RES_RST;
    i_mdm_host.write_mode(m);
  endtask

  task automatic ldv(input logic [15:0] d, input logic [15:0] s);
    if (mode[3:0] == mdm_pkg::OP_INIT16)
      res = {16'h0000, s};
    else if (mode[3:0] == mdm_pkg::OP_INIT32)
      res = {d, s};
    i_mdm_host.load(d, s);
  endtask

  task automatic op(input logic [15:0] d, input logic [15:0] s);
    logic [31:0] p;
    logic [3:0]  f;
    logic [31:0] sm;
    int          lat;
    f = mdm_pkg::FLAGS_NONE;
    p = $signed(d) * $signed(s);
    case (mode[3:0])
      mdm_pkg::OP_MULU: res = d * s;
      mdm_pkg::OP_MULS: res = p;
      mdm_pkg::OP_DIVU: res = {d % s, d / s};
      mdm_pkg::OP_DIVS: res = {16'($signed(d) % $signed(s)), 16'($signed(d) / $signed(s))};
      mdm_pkg::OP_MAC:
      begin
        sm = p + res;
        if (p[31] == res[31] && sm[31] != p[31])
          f = mdm_pkg::FLAGS_OVF;
        res = sm;
      end
      default: ;
    endcase
    exp_q.push_back({(mode[6:4] == mdm_pkg::OUT_HI) ? res[31:16] : res[15:0], f});
    i_mdm_host.xfer(d, s, lat);
    if (lat > 40)
    begin
      bad_count++;
      summarize();
    end
    if (mdm_pkg::is_div(mode[3:0]) === 1'b1)
      check(32'(lat >= 17 && lat <= 20), 32'h1);
    else
      check(32'(lat), 32'h1);
  endtask

  initial
  begin
    logic [15:0] a, b;
    mode = 7'h00;
    res  = mdm_pkg::RES_RST;
    repeat (4) @(negedge core_clk_i);
    srst_i = 1'b0;
    check({10'h000, busy_o, done_o, half_result_o, flags}, 32'h0);
    wm(7'h02);
    ldv(16'hA5C3, 16'h1E7F);
    wm(7'h13);
    op(16'h0000, 16'h0000);
    wm(7'h00);
    wm(7'h13);
    op(16'h0000, 16'h0000);
    wm(7'h01);
    ldv(16'hFFFF, 16'h8001);
    wm(7'h13);
    op(16'h0000, 16'h0000);
    for (int r = 0; r < 4; r++)
    begin
      foreach (tbl[i])
      begin
        wm(tbl[i]);
        a = 16'($random(seed));
        b = 16'($random(seed));
        // divisor kept legal, no signed overflow pair
        if (b == 16'h0000 || (a == 16'h8000 && b == 16'hFFFF))
          b = 16'h0001;
        op(a, b);
        // result survives a read and a foreign preload
        wm(7'h03 | (~tbl[i] & 7'h10));
        ldv(a, b);
        op(16'h0000, 16'h0000);
      end
    end
    wm(7'h02);
    ldv(16'h7FFF, 16'hFFFF);
    wm(7'h07);
    op(16'h0100, 16'h0100);
    op(16'h0003, 16'hFFFE);
    wm(7'h02);
    ldv(16'h8000, 16'h0000);
    wm(7'h17);
    op(16'hFFFF, 16'h0001);
    repeat (6)
      op(16'($random(seed)), 16'($random(seed)));
    repeat (4) @(negedge core_clk_i);
    check(32'(exp_q.size()), 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
